// ---- rtl/sist_pkg.sv ----
package sist_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] SOURCE_ADDR = 8'h12;
    localparam logic [7:0] CONFIG_ADDR = 8'h13;
    localparam logic [7:0] DATA_STATUS_ADDR = 8'h00;
    localparam logic [7:0] OUT_FIRST_ADDR = 8'h01;
    localparam logic [7:0] OUT_LAST_ADDR = 8'h05;
    localparam logic [7:0] BUFFER_STATUS_ADDR = 8'h0D;

    // ----------------------------------------
    // Source register bit positions
    // ----------------------------------------
    localparam int DATA_READY_BIT = 7;
    localparam int BUFFER_EVENT_BIT = 6;
    localparam int PRESSURE_WINDOW_BIT = 5;
    localparam int TEMP_WINDOW_BIT = 4;
    localparam int PRESSURE_THRESHOLD_BIT = 3;
    localparam int TEMP_THRESHOLD_BIT = 2;
    localparam int PRESSURE_DELTA_BIT = 1;
    localparam int TEMP_DELTA_BIT = 0;
    localparam int SOURCE_COUNT = 8;

    // ----------------------------------------
    // Event configuration fields and resets
    // ----------------------------------------
    localparam int CHANGE_MODE_BIT = 2;
    localparam int PRESSURE_EVENT_BIT = 1;
    localparam int TEMP_EVENT_BIT = 0;
    localparam int CONFIG_WIDTH = 3;
    localparam logic [2:0] CONFIG_RESET = 3'h0;
    localparam logic [7:0] SOURCE_RESET = 8'h00;

    // ----------------------------------------
    // Sample buffer limits
    // ----------------------------------------
    localparam logic [5:0] BUFFER_FULL_COUNT = 6'h20;
    localparam logic [5:0] WATERMARK_OFF = 6'h00;
endpackage

// ---- rtl/sist_source_bit.sv ----
`timescale 1ns/1ps
module sist_source_bit (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic cond,
    input wire logic enable,
    input wire logic clear,
    output logic flag
);
    logic cond_prev;
    logic set_now;

    // Rising edge of an enabled condition
    assign set_now = enable & cond & ~cond_prev;

    // Condition history for edge detection
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cond_prev <= 1'h0;
        end else if (ce) begin
            cond_prev <= cond;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flag <= 1'h0;
        end else if (ce) begin
            flag <= set_now | (flag & ~clear); // Set wins over clear
        end
    end

    set_edge_a: assert property (@(posedge clock) disable iff (!arst_n)
        ce && enable && cond && !cond_prev |=> flag)
        else $error("enabled rising condition did not set flag");

    off_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        !flag && (!enable || !ce) |=> !flag)
        else $error("flag set while its function was disabled");
endmodule

// ---- rtl/sist_core.sv ----
`timescale 1ns/1ps
module sist_core (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] int_enable,
    input wire logic new_data_flag,
    input wire logic data_overwrite_flag,
    input wire logic [5:0] buffer_sample_count,
    input wire logic [5:0] buffer_watermark_level,
    input wire logic pressure_sample_valid,
    input wire logic [15:0] pressure_value,
    input wire logic [15:0] pressure_target,
    input wire logic [15:0] pressure_window,
    input wire logic temp_sample_valid,
    input wire logic [7:0] temp_value,
    input wire logic [7:0] temp_target,
    input wire logic [7:0] temp_window,
    output logic [7:0] reg_rdata,
    output logic [7:0] interrupt_source_status,
    output logic [2:0] sensor_event_config
);
    // ----------------------------------------
    // Region compare helper
    // ----------------------------------------
    // Returns {above upper, at or above center, at or above lower}
    function automatic logic [2:0] region(input logic [16:0] val, input logic [16:0] tgt,
                                          input logic [16:0] win);
        logic [17:0] upper;
        logic [17:0] v_plus;
        upper = {1'h0, tgt} + {1'h0, win};
        v_plus = {1'h0, val} + {1'h0, win};
        region = {({1'h0, val} > upper), (val >= tgt), (v_plus >= {1'h0, tgt})};
    endfunction

    logic [2:0] p_region;
    logic [2:0] t_region;
    logic [2:0] p_region_prev;
    logic [2:0] t_region_prev;
    logic p_seen;
    logic t_seen;
    logic [15:0] p_last;
    logic [7:0] t_last;
    logic drdy_armed;
    logic fifo_cond;
    logic pw_cond;
    logic tw_cond;
    logic p_cross;
    logic t_cross;
    logic p_event;
    logic t_event;
    logic [7:0] cond;
    logic [7:0] clear;
    logic rd_source;
    logic rd_out;

    // ----------------------------------------
    // Event conditions
    // ----------------------------------------
    assign p_region = region({1'h0, pressure_value}, {1'h0, pressure_target},
                             {1'h0, pressure_window});
    assign t_region = region({9'h000, temp_value}, {9'h000, temp_target},
                             {9'h000, temp_window});

    assign fifo_cond = (buffer_sample_count == sist_pkg::BUFFER_FULL_COUNT)
        | ((buffer_watermark_level != sist_pkg::WATERMARK_OFF)
           & (buffer_sample_count == buffer_watermark_level));

    assign pw_cond = (pressure_window != 16'h0000) & p_region[0] & ~p_region[2];
    assign tw_cond = (temp_window != 8'h00) & t_region[0] & ~t_region[2];

    assign p_cross = pressure_sample_valid & p_seen & ((pressure_window == 16'h0000) ?
        (p_region[1] != p_region_prev[1]) : (p_region != p_region_prev));
    assign t_cross = temp_sample_valid & t_seen & ((temp_window == 8'h00) ?
        (t_region[1] != t_region_prev[1]) : (t_region != t_region_prev));

    // only on value change or on the first sample in mode 1
    assign p_event = pressure_sample_valid & sensor_event_config[sist_pkg::PRESSURE_EVENT_BIT]
        & (~sensor_event_config[sist_pkg::CHANGE_MODE_BIT] | ~p_seen
           | (pressure_value != p_last));
    assign t_event = temp_sample_valid & sensor_event_config[sist_pkg::TEMP_EVENT_BIT]
        & (~sensor_event_config[sist_pkg::CHANGE_MODE_BIT] | ~t_seen
           | (temp_value != t_last));

    // Condition vector in source bit order
    always_comb begin
        cond = 8'h00;
        cond[sist_pkg::DATA_READY_BIT] = new_data_flag | data_overwrite_flag;
        cond[sist_pkg::BUFFER_EVENT_BIT] = fifo_cond;
        cond[sist_pkg::PRESSURE_WINDOW_BIT] = pw_cond;
        cond[sist_pkg::TEMP_WINDOW_BIT] = tw_cond;
        cond[sist_pkg::PRESSURE_THRESHOLD_BIT] = p_cross;
        cond[sist_pkg::TEMP_THRESHOLD_BIT] = t_cross;
        // change events in bits 1 and 0
        cond[sist_pkg::PRESSURE_DELTA_BIT] = p_event;
        cond[sist_pkg::TEMP_DELTA_BIT] = t_event;
    end

    // ----------------------------------------
    // Read side effects
    // ----------------------------------------
    assign rd_source = reg_rd & (reg_addr == sist_pkg::SOURCE_ADDR);
    assign rd_out = reg_rd & (reg_addr >= sist_pkg::OUT_FIRST_ADDR)
        & (reg_addr <= sist_pkg::OUT_LAST_ADDR);

    // Clear strobes per source bit
    always_comb begin
        clear = {8{rd_source}};
        clear[sist_pkg::DATA_READY_BIT] = drdy_armed & rd_out;
        clear[sist_pkg::BUFFER_EVENT_BIT] = reg_rd
            & (reg_addr == sist_pkg::BUFFER_STATUS_ADDR);
    end

    // Data-ready clear sequence tracker
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            drdy_armed <= 1'h0;
        end else if (ce) begin
            if (reg_rd && reg_addr == sist_pkg::DATA_STATUS_ADDR) begin
                drdy_armed <= 1'h1;
            end else if (rd_out) begin
                drdy_armed <= 1'h0;
            end
        end
    end

    // ----------------------------------------
    // Sample history
    // ----------------------------------------
    // Last pressure region and value
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            p_seen <= 1'h0;
            p_region_prev <= 3'h0;
            p_last <= 16'h0000;
        end else if (ce && pressure_sample_valid) begin
            p_seen <= 1'h1;
            p_region_prev <= p_region;
            p_last <= pressure_value;
        end
    end

    // Last temperature region and value
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            t_seen <= 1'h0;
            t_region_prev <= 3'h0;
            t_last <= 8'h00;
        end else if (ce && temp_sample_valid) begin
            t_seen <= 1'h1;
            t_region_prev <= t_region;
            t_last <= temp_value;
        end
    end

    // ----------------------------------------
    // Source bits
    // ----------------------------------------
    for (genvar i = 0; i < sist_pkg::SOURCE_COUNT; i++) begin : g_src
        sist_source_bit u_bit (
            .clock(clock),
            .arst_n(arst_n),
            .ce(ce),
            .cond(cond[i]),
            .enable(int_enable[i]),
            .clear(clear[i]),
            .flag(interrupt_source_status[i])
        );
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    // Event configuration register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sensor_event_config <= sist_pkg::CONFIG_RESET;
        end else if (ce && reg_wr && reg_addr == sist_pkg::CONFIG_ADDR) begin
            sensor_event_config <= reg_wdata[sist_pkg::CONFIG_WIDTH-1:0];
        end
    end

    // Registered read data
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (ce && reg_rd) begin
            case (reg_addr)
                sist_pkg::SOURCE_ADDR: reg_rdata <= interrupt_source_status;
                sist_pkg::CONFIG_ADDR: reg_rdata <= {5'h00, sensor_event_config};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    fifo_rise_a: assert property (
        ce && $rose(fifo_cond) && int_enable[sist_pkg::BUFFER_EVENT_BIT]
        |=> interrupt_source_status[sist_pkg::BUFFER_EVENT_BIT])
        else $error("buffer event did not set its source bit");
    fifo_hold_a: assert property (
        interrupt_source_status[sist_pkg::BUFFER_EVENT_BIT]
        && !(ce && clear[sist_pkg::BUFFER_EVENT_BIT])
        |=> interrupt_source_status[sist_pkg::BUFFER_EVENT_BIT])
        else $error("buffer source bit cleared without status read");
    wm_zero_a: assert property (
        buffer_watermark_level == sist_pkg::WATERMARK_OFF
        && buffer_sample_count != sist_pkg::BUFFER_FULL_COUNT |-> !fifo_cond)
        else $error("watermark event with zero level");
    pw_zero_a: assert property (
        pressure_window == 16'h0000 |-> !pw_cond)
        else $error("pressure window event with zero window");
    tw_zero_a: assert property (
        temp_window == 8'h00 |-> !tw_cond)
        else $error("temperature window event with zero window");
    cfg_read_a: assert property (
        ce && reg_rd && reg_addr == sist_pkg::CONFIG_ADDR |=> reg_rdata[7:3] == 5'h00)
        else $error("reserved configuration bits read nonzero");
    every_sample_a: assert property (
        pressure_sample_valid && sensor_event_config[sist_pkg::PRESSURE_EVENT_BIT]
        && !sensor_event_config[sist_pkg::CHANGE_MODE_BIT] |-> p_event)
        else $error("missing pressure event in every-sample mode");
    same_value_a: assert property (
        temp_sample_valid && t_seen && sensor_event_config[sist_pkg::CHANGE_MODE_BIT]
        && temp_value == t_last |-> !t_event)
        else $error("temperature event without a change");
    p_off_a: assert property (
        !sensor_event_config[sist_pkg::PRESSURE_EVENT_BIT] |-> !p_event)
        else $error("pressure event while disabled");
    t_off_a: assert property (
        !sensor_event_config[sist_pkg::TEMP_EVENT_BIT] |-> !t_event)
        else $error("temperature event while disabled");
    drdy_clear_a: assert property (
        ce && drdy_armed && rd_out && !(cond[sist_pkg::DATA_READY_BIT]
        && int_enable[sist_pkg::DATA_READY_BIT])
        |=> !interrupt_source_status[sist_pkg::DATA_READY_BIT] && !drdy_armed)
        else $error("data-ready bit not cleared by read sequence");
endmodule

// ---- tb/sist_host.sv ----
`timescale 1ns/1ps
// ----
// Host side of the register port
// ----
module sist_host (
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata
);
    logic [7:0] exp_q[$];
    logic use_q[$];

    // Idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_rd = 1'h0;
        reg_wr = 1'h0;
        reg_wdata = 8'h00;
    end

    // One read strobe, expected byte noted
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic use_it);
        @(negedge clock);
        reg_addr = addr;
        reg_rd = 1'h1;
        exp_q.push_back(exp);
        use_q.push_back(use_it);
        @(negedge clock);
        reg_rd = 1'h0;
    endtask

    // One write strobe, data scrambled after
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'h1;
        @(negedge clock);
        reg_wr = 1'h0;
        reg_wdata = ~data;
    endtask

    task automatic ready_clear;
        rd(8'h00, 8'h00, 1'h0);
        rd(8'h01, 8'h00, 1'h0);
    endtask
endmodule

// ---- tb/sensor_interrupt_source_and_event_config_test.sv ----
`timescale 1ns/1ps
module sensor_interrupt_source_and_event_config_test;
    // ----
    // Signals
    // ----
    logic clock = 1'h0;
    logic arst_n = 1'h0;
    logic ce = 1'h1;
    logic [7:0] int_enable = 8'hFF;
    logic new_data_flag = 1'h0;
    logic data_overwrite_flag = 1'h0;
    logic [5:0] buffer_sample_count = 6'h00;
    logic [5:0] buffer_watermark_level = 6'h00;
    logic pressure_sample_valid = 1'h0;
    logic [15:0] pressure_value = 16'h03E8;
    logic [15:0] pressure_target = 16'h03E8;
    logic [15:0] pressure_window = 16'h0000;
    logic temp_sample_valid = 1'h0;
    logic [7:0] temp_value = 8'h32;
    logic [7:0] temp_target = 8'h32;
    logic [7:0] temp_window = 8'h00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, interrupt_source_status, t, e;
    logic reg_rd, reg_wr, u;
    logic [2:0] sensor_event_config;
    logic [15:0] v;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 35113;

    always #10 clock = ~clock;

    sist_core dut (.clock, .arst_n, .ce, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .int_enable,
        .new_data_flag, .data_overwrite_flag, .buffer_sample_count, .buffer_watermark_level,
        .pressure_sample_valid, .pressure_value, .pressure_target, .pressure_window,
        .temp_sample_valid, .temp_value, .temp_target, .temp_window, .reg_rdata,
        .interrupt_source_status, .sensor_event_config);
    sist_host host (.clock, .reg_addr, .reg_rd, .reg_wr, .reg_wdata);

    // ----
    // Helpers
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tick;
        @(negedge clock);
    endtask

    task automatic ps(input logic [15:0] val);
        @(negedge clock);
        pressure_value = val;
        pressure_sample_valid = 1'h1;
        @(negedge clock);
        pressure_sample_valid = 1'h0;
    endtask

    task automatic ts(input logic [7:0] val);
        @(negedge clock);
        temp_value = val;
        temp_sample_valid = 1'h1;
        @(negedge clock);
        temp_sample_valid = 1'h0;
    endtask

    // Read data compared one edge after each read strobe flagged for use
    always @(posedge clock) begin
        if (reg_rd === 1'h1) begin
            @(negedge clock);
            e = host.exp_q.pop_front();
            u = host.use_q.pop_front();
            if (u) check(reg_rdata, e);
        end
    end

    // Watchdog against a hang
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    // ----
    // Tests
    // ----
    initial begin
        repeat (4) @(negedge clock);
        arst_n = 1'h1;
        check(interrupt_source_status, 8'h00);
        host.rd(8'h12, 8'h00, 1'h1);
        host.rd(8'h13, 8'h00, 1'h1);
        host.wr(8'h13, 8'hFF);
        host.rd(8'h13, 8'h07, 1'h1);
        check({5'h00, sensor_event_config}, 8'h07);
        host.rd(8'h20, 8'h00, 1'h1);
        host.wr(8'h12, 8'hFF);
        check(interrupt_source_status, 8'h00);
        check({5'h00, sensor_event_config}, 8'h07);
        host.wr(8'h13, 8'h00);
        $display("test registers done");
        int_enable = 8'h7F;
        data_overwrite_flag = 1'h1;
        tick();
        check(interrupt_source_status, 8'h00);
        data_overwrite_flag = 1'h0;
        int_enable = 8'hFF;
        tick();
        new_data_flag = 1'h1;
        tick();
        check(interrupt_source_status, 8'h80);
        new_data_flag = 1'h0;
        host.rd(8'h12, 8'h80, 1'h1);
        check(interrupt_source_status, 8'h80);
        host.ready_clear();
        check(interrupt_source_status, 8'h00);
        $display("test data ready done");
        buffer_sample_count = 6'h01;
        tick();
        buffer_sample_count = 6'h00;
        tick();
        check(interrupt_source_status, 8'h00);
        buffer_watermark_level = 6'h05;
        buffer_sample_count = 6'h05;
        tick();
        check(interrupt_source_status, 8'h40);
        host.rd(8'h12, 8'h40, 1'h1);
        check(interrupt_source_status, 8'h40);
        host.rd(8'h0D, 8'h00, 1'h0);
        check(interrupt_source_status, 8'h00);
        buffer_sample_count = 6'h00;
        tick();
        buffer_sample_count = 6'h20;
        tick();
        check(interrupt_source_status, 8'h40);
        host.rd(8'h0D, 8'h00, 1'h0);
        $display("test buffer done");
        pressure_window = 16'h000A;
        pressure_value = 16'h03F2;
        temp_window = 8'h03;
        temp_value = 8'h35;
        tick();
        check(interrupt_source_status, 8'h30);
        host.rd(8'h12, 8'h30, 1'h1);
        check(interrupt_source_status, 8'h00);
        pressure_window = 16'h0000;
        temp_window = 8'h00;
        $display("test windows done");
        ps(16'h0384);
        ps(16'h044C);
        check(interrupt_source_status, 8'h08);
        host.rd(8'h12, 8'h08, 1'h1);
        ps(16'h04B0);
        check(interrupt_source_status, 8'h00);
        pressure_window = 16'h000A;
        ps(16'h03D4);
        host.rd(8'h12, 8'h08, 1'h1);
        ps(16'h03E3);
        check(interrupt_source_status, 8'h28);
        host.rd(8'h12, 8'h28, 1'h1);
        pressure_window = 16'h0000;
        ts(8'h28);
        ts(8'h3C);
        check(interrupt_source_status, 8'h04);
        host.rd(8'h12, 8'h04, 1'h1);
        $display("test thresholds done");
        v = 16'h8000 | {4'h0, 12'($random(seed))};
        t = 8'h80 | 8'($random(seed));
        host.wr(8'h13, 8'h02);
        ps(v);
        check(interrupt_source_status, 8'h0A);
        host.rd(8'h12, 8'h0A, 1'h1);
        ps(v);
        check(interrupt_source_status, 8'h02);
        host.rd(8'h12, 8'h02, 1'h1);
        host.wr(8'h13, 8'h06);
        ps(v);
        check(interrupt_source_status, 8'h00);
        ps(v + 16'h0001);
        check(interrupt_source_status, 8'h02);
        host.rd(8'h12, 8'h02, 1'h1);
        host.wr(8'h13, 8'h05);
        ts(t);
        ps(v + 16'h0005);
        check(interrupt_source_status, 8'h01);
        host.rd(8'h12, 8'h01, 1'h1);
        ts(t);
        check(interrupt_source_status, 8'h00);
        $display("test change events done");
        ce = 1'h0;
        new_data_flag = 1'h1;
        tick();
        check(interrupt_source_status, 8'h00);
        ce = 1'h1;
        tick();
        check(interrupt_source_status, 8'h80);
        new_data_flag = 1'h0;
        host.ready_clear();
        check(interrupt_source_status, 8'h00);
        $display("test clock enable done");
        repeat (3) @(negedge clock);
        end_sim();
    end
endmodule
